//--- fls_lock_status_regs.sv
// Behaviour
// RQ1: lock-state register reads fully, software writes to it are ignored.
// RQ2: at reset, lock-state register loads the stored nonvolatile lock byte.
// RQ3: double-bit fault on the lock byte read sets every lock-state bit.
// RQ4: backdoor key access enabled only when key-enable field is 10.
// RQ5: part counts as unlocked only when lock-state field is 10.
// RQ6: successful backdoor unlock forces lock-state field to 10.
// RQ7: software should keep reserved nonvolatile bits five to two erased.
// RQ8: parameter index register: only index field read/write, rest reads zero.
// RQ9: index field selects how many parameter array words are accessed.
// RQ10: protection status register reads fully, software writes are ignored.
// RQ11: status bit 7 shows protection override active, else reads 0.
// RQ12: writing a changed wait-state field clears the acknowledge bit.
// RQ13: reads use old wait-states until switched, then acknowledge sets.
// RQ14: software checks acknowledge is 1 before changing clock setup.
// RQ15: wait-state field at config bits 3:2; writes while busy ignored.
// RQ16: after reset the maximum wait-state setting is selected.
// RQ17: after reset acknowledge reads 1 and override status reads 0.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fls_map.svh"

module fls_lock_status_regs import fls_pkg::*; (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // nonvolatile lock byte pins
    input wire logic [7:0] nv_lock_byte,
    input wire logic nv_dbl_fault,
    // controller side
    input wire logic backdoor_unlock,
    input wire logic prot_override,
    input wire logic command_complete_flag,
    input wire logic array_read_busy,
    output logic [1:0] wait_state_eff,
    output logic [1:0] param_index_field,
    output logic backdoor_key_enable,
    output logic part_unlocked,
    output logic wait_switch_acknowledge
);

    fls_state_s r;
    fls_state_s n;
    logic addr_ok;

    function automatic logic [5:0] fls_idx(input logic [31:0] a);
        fls_idx = a[7:2];
    endfunction

    function automatic logic [31:0] fls_rd(input logic [5:0] idx, input fls_state_s s);
        fls_rd = 32'h0000_0000;
        case (idx)
            `FLS_IDX_LOCK: fls_rd[7:0] = s.lock_reg; // [RQ1]
            `FLS_IDX_PINDEX: fls_rd[1:0] = s.pindex_reg; // [RQ8]
            `FLS_IDX_PSTAT: begin
                fls_rd[`FLS_OVR_BIT] = s.ovr_reg; // [RQ10] [RQ11]
                fls_rd[`FLS_ACK_BIT] = s.ack_reg;
            end
            `FLS_IDX_CONFIG: fls_rd[`FLS_WS_HI:`FLS_WS_LO] = s.ws_cfg_reg;
            default: fls_rd = 32'h0000_0000;
        endcase
    endfunction

    always_comb begin
        n = r;
        addr_ok = hsel && hready && htrans[1] && (r.st == FLS_ST_RUN);
        if (ce) begin
            // lock byte pins are only sampled through the second stage
            n.byte_s1_reg = nv_lock_byte;
            n.byte_s2_reg = r.byte_s1_reg;
            n.flt_s1_reg = nv_dbl_fault;
            n.flt_s2_reg = r.flt_s1_reg;
            case (r.st)
                FLS_ST_SYNC0: n.st = FLS_ST_SYNC1;
                FLS_ST_SYNC1: n.st = FLS_ST_LOAD;
                FLS_ST_LOAD: begin
                    if (r.flt_s2_reg) begin
                        n.lock_reg = `FLS_LOCK_FAULT; // [RQ3]
                    end else begin
                        n.lock_reg = r.byte_s2_reg; // [RQ2]
                    end
                    n.hready_reg = 1'b1;
                    n.st = FLS_ST_RUN;
                end
                FLS_ST_RUN: n.st = FLS_ST_RUN;
                default: n.st = FLS_ST_SYNC0;
            endcase
            n.ovr_reg = prot_override; // [RQ11]
            // switch only between array reads so no read sees a half change
            if (!r.ack_reg && !array_read_busy) begin
                n.ws_eff_reg = r.ws_cfg_reg; // [RQ13]
                n.ack_reg = 1'b1;
            end
            if ((r.st == FLS_ST_RUN) && backdoor_unlock) begin
                n.lock_reg[`FLS_SEC_HI:`FLS_SEC_LO] = `FLS_SEC_UNLOCKED; // [RQ6]
            end
            // data phase; lock and status offsets have no write path
            if (r.dp_wr_reg) begin
                case (r.dp_idx_reg)
                    `FLS_IDX_PINDEX: n.pindex_reg = hwdata[1:0]; // [RQ8] [RQ9]
                    `FLS_IDX_CONFIG: begin
                        if (command_complete_flag &&
                            (hwdata[`FLS_WS_HI:`FLS_WS_LO] != r.ws_cfg_reg)) begin // [RQ15]
                            n.ws_cfg_reg = hwdata[`FLS_WS_HI:`FLS_WS_LO];
                            n.ack_reg = 1'b0; // [RQ12]
                        end
                    end
                    default: n.dp_wr_reg = 1'b0;
                endcase
            end
            // address phase; non-word writes are dropped
            n.dp_wr_reg = addr_ok && hwrite && (hsize == `FLS_HSIZE_WORD);
            n.dp_idx_reg = fls_idx(haddr);
            n.hrdata_reg = (addr_ok && !hwrite) ? fls_rd(fls_idx(haddr), r) : 32'h0000_0000;
            n.hresp_reg = 1'b0;
            n.key_en_reg = (n.lock_reg[`FLS_KEY_HI:`FLS_KEY_LO] == `FLS_KEY_ENABLED); // [RQ4]
            n.unlocked_reg = (n.lock_reg[`FLS_SEC_HI:`FLS_SEC_LO] == `FLS_SEC_UNLOCKED); // [RQ5]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r.st <= FLS_ST_SYNC0;
            r.lock_reg <= `FLS_LOCK_RST;
            r.pindex_reg <= `FLS_PINDEX_RST;
            r.ws_cfg_reg <= `FLS_WS_MAX; // [RQ16]
            r.ws_eff_reg <= `FLS_WS_MAX;
            r.ack_reg <= 1'b1; // [RQ17]
            r.ovr_reg <= 1'b0;
            r.key_en_reg <= 1'b0;
            r.unlocked_reg <= 1'b0;
            r.dp_wr_reg <= 1'b0;
            r.dp_idx_reg <= 6'h00;
            r.hrdata_reg <= 32'h0000_0000;
            r.hready_reg <= 1'b0;
            r.hresp_reg <= 1'b0;
            r.byte_s1_reg <= 8'h00;
            r.byte_s2_reg <= 8'h00;
            r.flt_s1_reg <= 1'b0;
            r.flt_s2_reg <= 1'b0;
        end else begin
            r <= n;
        end
    end

    assign hrdata = r.hrdata_reg;
    assign hreadyout = r.hready_reg;
    assign hresp = r.hresp_reg;
    assign wait_state_eff = r.ws_eff_reg;
    assign param_index_field = r.pindex_reg;
    assign backdoor_key_enable = r.key_en_reg;
    assign part_unlocked = r.unlocked_reg;
    assign wait_switch_acknowledge = r.ack_reg;

    logic wr_lock;
    logic wr_pstat;
    logic wr_idx;
    logic wr_cfg;
    assign wr_lock = ce && r.dp_wr_reg && (r.dp_idx_reg == `FLS_IDX_LOCK);
    assign wr_pstat = ce && r.dp_wr_reg && (r.dp_idx_reg == `FLS_IDX_PSTAT);
    assign wr_idx = ce && r.dp_wr_reg && (r.dp_idx_reg == `FLS_IDX_PINDEX);
    assign wr_cfg = ce && r.dp_wr_reg && (r.dp_idx_reg == `FLS_IDX_CONFIG);
    logic rd_take;
    logic [5:0] rd_idx;
    assign rd_take = ce && addr_ok && !hwrite;
    assign rd_idx = fls_idx(haddr);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_lock_readonly: assert property ( // [RQ1]
        wr_lock && !backdoor_unlock |=> $stable(r.lock_reg))
        else $error("lock register changed by a write");

    chk_load_byte: assert property ( // [RQ2]
        ce && (r.st == FLS_ST_LOAD) && !r.flt_s2_reg |=> r.lock_reg == $past(r.byte_s2_reg))
        else $error("lock byte not loaded at reset");

    chk_fault_lock: assert property ( // [RQ3]
        ce && (r.st == FLS_ST_LOAD) && r.flt_s2_reg |=> r.lock_reg == 8'hFF && !backdoor_key_enable)
        else $error("fault did not lock the part");

    chk_key_enable: assert property ( // [RQ4]
        backdoor_key_enable == (r.lock_reg[7:6] == 2'h2))
        else $error("key enable decode wrong");

    chk_unlock_view: assert property ( // [RQ5]
        part_unlocked == (r.lock_reg[1:0] == 2'h2))
        else $error("unlock decode wrong");

    chk_backdoor_force: assert property ( // [RQ6]
        ce && backdoor_unlock && (r.st == FLS_ST_RUN) |=> r.lock_reg[1:0] == 2'h2 && part_unlocked)
        else $error("backdoor unlock did not force field");

    chk_index_write: assert property ( // [RQ8]
        wr_idx |=> param_index_field == $past(hwdata[1:0]))
        else $error("index field not written");

    chk_status_ro: assert property ( // [RQ10]
        wr_pstat && r.ack_reg && !wr_cfg |=> r.ack_reg)
        else $error("status register changed by a write");

    chk_override_bit: assert property ( // [RQ11]
        ce |=> r.ovr_reg == $past(prot_override))
        else $error("override status does not follow");

    chk_ack_clear: assert property ( // [RQ12]
        wr_cfg && command_complete_flag && (hwdata[3:2] != r.ws_cfg_reg) |=> !wait_switch_acknowledge)
        else $error("acknowledge not cleared on change");

    chk_ack_set: assert property ( // [RQ13]
        ce && !r.ack_reg && !array_read_busy && !wr_cfg |=>
        wait_switch_acknowledge && wait_state_eff == $past(r.ws_cfg_reg))
        else $error("wait switch not completed");

    chk_old_waits: assert property ( // [RQ13]
        !r.ack_reg && array_read_busy |=> $stable(wait_state_eff))
        else $error("wait states changed during a read");

    chk_busy_write: assert property ( // [RQ15]
        wr_cfg && !command_complete_flag |=> $stable(r.ws_cfg_reg))
        else $error("wait field written while busy");

    chk_reset_vals: assert property ( // [RQ16] [RQ17]
        r.st == FLS_ST_SYNC0 |-> wait_state_eff == 2'h3 && wait_switch_acknowledge && !r.ovr_reg)
        else $error("reset values wrong");

    // read answers must match the register contents of the address-phase cycle
    chk_lock_read: assert property ( // [RQ1]
        rd_take && (rd_idx == `FLS_IDX_LOCK) |=> hrdata == {24'h00_0000, $past(r.lock_reg)})
        else $error("lock register read wrong");

    chk_index_read: assert property ( // [RQ8]
        rd_take && (rd_idx == `FLS_IDX_PINDEX) |=> hrdata == {30'h0000_0000, $past(r.pindex_reg)})
        else $error("index register read wrong");

    chk_status_read: assert property ( // [RQ10]
        rd_take && (rd_idx == `FLS_IDX_PSTAT) |=> hrdata == {24'h00_0000, $past(r.ovr_reg), 6'h00, $past(r.ack_reg)})
        else $error("status register read wrong");

    chk_cfg_read: assert property ( // [RQ15]
        rd_take && (rd_idx == `FLS_IDX_CONFIG) |=> hrdata == {28'h000_0000, $past(r.ws_cfg_reg), 2'h0})
        else $error("wait field read wrong");

    chk_index_hold: assert property ( // [RQ9]
        !wr_idx |=> $stable(param_index_field))
        else $error("index field changed without a write");

    chk_cfg_hold: assert property ( // [RQ15]
        !wr_cfg |=> $stable(r.ws_cfg_reg))
        else $error("wait field changed without a write");

    chk_ack_hold: assert property ( // [RQ12]
        r.ack_reg && !wr_cfg |=> wait_switch_acknowledge)
        else $error("acknowledge dropped without a write");

    chk_eff_hold: assert property ( // [RQ13]
        r.ack_reg |=> $stable(wait_state_eff))
        else $error("wait states changed with no switch pending");

    chk_eff_matches: assert property ( // [RQ13]
        r.ack_reg |-> wait_state_eff == r.ws_cfg_reg)
        else $error("acknowledge set but setting not in use");

    chk_lock_hold: assert property ( // [RQ1]
        (r.st != FLS_ST_LOAD) && !backdoor_unlock |=> $stable(r.lock_reg))
        else $error("lock register changed outside load");

    chk_backdoor_keep: assert property ( // [RQ6]
        ce && backdoor_unlock && (r.st == FLS_ST_RUN) |=> r.lock_reg[7:2] == $past(r.lock_reg[7:2]))
        else $error("backdoor unlock touched other bits");

    chk_load_once: assert property ( // [RQ2]
        r.st == FLS_ST_RUN |=> r.st == FLS_ST_RUN)
        else $error("lock byte reloaded outside reset");

    chk_ws_boot: assert property ( // [RQ16]
        r.st != FLS_ST_RUN |-> r.ws_cfg_reg == `FLS_WS_MAX)
        else $error("wait field not at maximum after reset");

    chk_ready_run: assert property ( // [RQ2]
        r.st != FLS_ST_RUN |-> !hreadyout)
        else $error("bus answered before lock byte loaded");

    cov_load_fault: cover property (ce && (r.st == FLS_ST_LOAD) && r.flt_s2_reg);
    cov_backdoor: cover property (ce && backdoor_unlock && (r.st == FLS_ST_RUN));
    cov_wait_switch: cover property (wr_cfg && command_complete_flag ##[1:20] wait_switch_acknowledge);
    cov_busy_write: cover property (wr_cfg && !command_complete_flag);
    cov_index_write: cover property (wr_idx);

endmodule

`default_nettype wire

//--- fls_map.svh
`ifndef FLS_MAP_SVH
`define FLS_MAP_SVH

// register indices, byte address is four times the index
`define FLS_IDX_LOCK 6'h01
`define FLS_IDX_PINDEX 6'h02
`define FLS_IDX_PSTAT 6'h03
`define FLS_IDX_CONFIG 6'h04

// field positions
`define FLS_KEY_HI 7
`define FLS_KEY_LO 6
`define FLS_SEC_HI 1
`define FLS_SEC_LO 0
`define FLS_OVR_BIT 7
`define FLS_ACK_BIT 0
`define FLS_WS_HI 3
`define FLS_WS_LO 2

// encodings
`define FLS_KEY_ENABLED 2'h2
`define FLS_SEC_UNLOCKED 2'h2
`define FLS_HSIZE_WORD 3'h2

// reset and fault values
`define FLS_LOCK_RST 8'hFF
`define FLS_LOCK_FAULT 8'hFF
`define FLS_WS_MAX 2'h3
`define FLS_PINDEX_RST 2'h0

`endif

//--- fls_pkg.sv
package fls_pkg;

    typedef enum logic [1:0] {
        FLS_ST_SYNC0,
        FLS_ST_SYNC1,
        FLS_ST_LOAD,
        FLS_ST_RUN
    } fls_state_e;

    typedef struct packed {
        fls_state_e st;
        logic [7:0] lock_reg;
        logic [1:0] pindex_reg;
        logic [1:0] ws_cfg_reg;
        logic [1:0] ws_eff_reg;
        logic ack_reg;
        logic ovr_reg;
        logic key_en_reg;
        logic unlocked_reg;
        logic dp_wr_reg;
        logic [5:0] dp_idx_reg;
        logic [31:0] hrdata_reg;
        logic hready_reg;
        logic hresp_reg;
        logic [7:0] byte_s1_reg;
        logic [7:0] byte_s2_reg;
        logic flt_s1_reg;
        logic flt_s2_reg;
    } fls_state_s;

endpackage

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fls_map.svh"

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end

module testbench import fls_pkg::*;;
    logic hclk = 0, hresetn = 0, ce = 1, hsel = 1, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, r;
    logic [1:0] htrans = 0, wait_state_eff, param_index_field;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, backdoor_key_enable, part_unlocked, wait_switch_acknowledge;
    logic [7:0] nv_lock_byte = 8'hFF, b;
    logic nv_dbl_fault = 0, backdoor_unlock = 0, prot_override = 0;
    logic command_complete_flag = 1, array_read_busy = 0;
    logic [31:0] seed = 32'hF65D;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    wire hready;
    assign hready = hreadyout;

    always #2.5 hclk = ~hclk;

    fls_lock_status_regs fls_lock_status_regs_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nv_lock_byte(nv_lock_byte),
        .nv_dbl_fault(nv_dbl_fault), .backdoor_unlock(backdoor_unlock), .prot_override(prot_override),
        .command_complete_flag(command_complete_flag), .array_read_busy(array_read_busy),
        .wait_state_eff(wait_state_eff), .param_index_field(param_index_field),
        .backdoor_key_enable(backdoor_key_enable), .part_unlocked(part_unlocked),
        .wait_switch_acknowledge(wait_switch_acknowledge));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] adr(logic [5:0] idx);
        return {24'h000000, idx, 2'b00};
    endfunction

    // a double-bit fault on the stored byte leaves the part locked with the key closed
    function automatic logic [7:0] exp_lock(logic [7:0] v, logic f);
        return f ? 8'hFF : v;
    endfunction

    task automatic tally_and_finish();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one single transfer; the master waits on hready, never on a fixed count
    task automatic ahb(input logic w, input logic [5:0] idx, input logic [31:0] wd, input logic [2:0] sz,
            output logic [31:0] q);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= adr(idx);
        hwrite <= w;
        hsize <= sz;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic do_reset(input logic [7:0] v, input logic f);
        logic [7:0] e;
        e = exp_lock(v, f);
        @(posedge hclk);
        nv_lock_byte <= v;
        nv_dbl_fault <= f;
        hresetn <= 0;
        repeat (5) @(posedge hclk);
        `CHK(wait_switch_acknowledge, 1'b1)
        `CHK(wait_state_eff, `FLS_WS_MAX)
        `CHK(hreadyout, 1'b0)
        hresetn <= 1;
        while (hreadyout !== 1'b1) @(posedge hclk);
        @(posedge hclk);
        ahb(0, `FLS_IDX_LOCK, 0, 3'h2, rd);
        `CHK(rd, {24'h000000, e})
        `CHK(backdoor_key_enable, e[7:6] == `FLS_KEY_ENABLED)
        `CHK(part_unlocked, e[1:0] == `FLS_SEC_UNLOCKED)
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        // every key and lock code, reserved bits kept erased as software should
        for (int i = 0; i < 16; i++) begin
            do_reset({i[1:0], 4'hF, i[3:2]}, 1'b0);
        end
        r = xs();
        b = r[7:0] | 8'h3C;
        do_reset(b, 1'b1);
        r = xs();
        b = {r[7:6], 6'h3C};
        do_reset(b, 1'b0);
        ahb(1, `FLS_IDX_LOCK, xs(), 3'h2, rd);
        ahb(0, `FLS_IDX_LOCK, 0, 3'h2, rd);
        `CHK(rd, {24'h000000, b})
        @(posedge hclk) backdoor_unlock <= 1;
        @(posedge hclk) backdoor_unlock <= 0;
        ahb(0, `FLS_IDX_LOCK, 0, 3'h2, rd);
        `CHK(rd, {24'h000000, b[7:2], 2'b10})
        `CHK(part_unlocked, 1'b1)
        for (int i = 0; i < 6; i++) begin
            r = xs();
            ahb(1, `FLS_IDX_PINDEX, r, 3'h2, rd);
            ahb(1, `FLS_IDX_PINDEX, ~r, 3'h0, rd);
            ahb(0, `FLS_IDX_PINDEX, 0, 3'h2, rd);
            `CHK(rd, {30'h0, r[1:0]})
            `CHK(param_index_field, r[1:0])
        end
        ahb(0, 6'h3F, 0, 3'h2, rd);
        `CHK(rd, 32'h0)
        @(posedge hclk) prot_override <= 1;
        ahb(1, `FLS_IDX_PSTAT, 32'h0, 3'h2, rd);
        ahb(0, `FLS_IDX_PSTAT, 0, 3'h2, rd);
        `CHK(rd, 32'h00000081)
        @(posedge hclk) prot_override <= 0;
        ahb(0, `FLS_IDX_PSTAT, 0, 3'h2, rd);
        `CHK(rd, 32'h00000001)
        // array busy holds the old setting so the pending window is visible
        @(posedge hclk) array_read_busy <= 1;
        ahb(1, `FLS_IDX_CONFIG, (xs() & 32'hFFFFFFF3) | 32'h4, 3'h2, rd);
        @(posedge hclk);
        `CHK(wait_switch_acknowledge, 1'b0)
        `CHK(wait_state_eff, 2'h3)
        ahb(0, `FLS_IDX_PSTAT, 0, 3'h2, rd);
        `CHK(rd, 32'h0)
        // clock enable low freezes the pending switch even with the array idle
        ce <= 0;
        array_read_busy <= 0;
        repeat (2) @(posedge hclk);
        `CHK(wait_switch_acknowledge, 1'b0)
        ce <= 1;
        repeat (2) @(posedge hclk);
        `CHK(wait_switch_acknowledge, 1'b1)
        `CHK(wait_state_eff, 2'h1)
        ahb(0, `FLS_IDX_PSTAT, 0, 3'h2, rd);
        `CHK(rd, 32'h00000001)
        command_complete_flag <= 0;
        ahb(1, `FLS_IDX_CONFIG, 32'h8, 3'h2, rd);
        ahb(0, `FLS_IDX_CONFIG, 0, 3'h2, rd);
        `CHK(rd, 32'h4)
        `CHK(wait_switch_acknowledge, 1'b1)
        `CHK(hresp, 1'b0)
        tally_and_finish();
    end
endmodule

`default_nettype wire
